// ### ebsc_bus_strobe.sv
// External bus strobe controller: ALE-type latch strobe, code read strobe,
// data read/write strobes, high address port, reset pin and code select.
// Assumes an APB master on pclk, one pclk per oscillator period.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "ebsc_defs.svh"

module ebsc_bus_strobe
   import ebsc_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Core requests
   input  wire logic        fetch_req,
   input  wire logic        data_req,
   input  wire logic        data_write,
   input  wire logic        data_wide,
   input  wire logic [15:0] bus_addr,
   input  wire logic        watchdog_reset,
   input  wire logic        security_level1,
   // Pins (two-way pins: input, output, enable low while driving)
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe_n,
   input  wire logic        latch_pin_in,
   output logic             latch_strobe,
   output logic             latch_oe_n,
   output logic             code_read_strobe_n,
   input  wire logic        external_code_select,
   input  wire logic        flash_programming,
   output logic [7:0]       high_addr_port,
   output logic [7:0]       low_addr_out,
   output logic [7:0]       port3_out,
   // Status to the core
   output logic             device_reset,
   output logic             program_pulse_in,
   output logic             fetch_external
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]  aux_reg, aux_next;
   logic [7:0]  clock_speed_control_reg, clock_speed_control_next;
   logic [7:0]  p3_reg, p3_next;
   logic        pready_reg, pready_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pslverr_reg, pslverr_next;
   logic [4:0]  rst_cnt_reg, rst_cnt_next;
   logic        dev_rst_reg, dev_rst_next;
   logic        ea_latch_reg, ea_latch_next;
   logic        ea_taken_reg, ea_taken_next;
   logic        ale_reg, ale_next;
   logic        code_read_strobe_n_reg, code_read_strobe_n_next;
   logic        wr_n_next, rd_n_next;
   logic [7:0]  p3o_reg;
   logic [7:0]  hi_reg, hi_next;
   logic [7:0]  lo_reg, lo_next;
   logic        rpo_reg, rpo_next, rpo_oe_n_reg;
   logic        program_pulse_in_reg, program_pulse_in_next, lat_oe_n_reg;
   logic        fext_reg, fext_next;
   ebsc_state_type st_reg, st_next;
   logic [3:0]  phase;
   logic        x2_active, cycle_end;
   logic        rst_level, ea_level, program_pulse_in_level;
   logic        ext_code, acc;
   logic [4:0]  rst_need;
   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   ebsc_phase_gen u_phase (
      .pclk      (pclk),
      .presetn   (presetn),
      .x2_req    (clock_speed_control_reg[`EBSC_BIT_DOUBLE_SPEED]),
      .phase     (phase),
      .x2_active (x2_active),
      .cycle_end (cycle_end)
   );
   ebsc_pin_sync #(.RESET_VAL(1'b0)) u_rst_sync (
      .pclk (pclk), .presetn (presetn), .pin_in (reset_pin_in), .level_out (rst_level)
   );
   ebsc_pin_sync #(.RESET_VAL(1'b0)) u_ea_sync (
      .pclk (pclk), .presetn (presetn), .pin_in (external_code_select), .level_out (ea_level)
   );
   ebsc_pin_sync #(.RESET_VAL(1'b0)) u_program_pulse_in_sync (
      .pclk (pclk), .presetn (presetn), .pin_in (latch_pin_in), .level_out (program_pulse_in_level)
   );
   // Byte address to register index decode.
   function automatic logic [1:0] hit(input logic [11:0] a);
      hit = (a == `EBSC_ADDR_AUX_CONTROL) ? 2'h1 :
            (a == `EBSC_ADDR_CLOCK_SPEED) ? 2'h2 :
            (a == `EBSC_ADDR_PORT3_LATCH) ? 2'h3 : 2'h0;
   endfunction

   // ----------------------------------------
   // APB register file, one wait state
   // ----------------------------------------
   always_comb
   begin
      acc          = psel && penable && !pready_reg;
      aux_next     = aux_reg;
      clock_speed_control_next   = clock_speed_control_reg;
      p3_next      = p3_reg;
      pready_next  = acc;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (acc && pwrite)
      begin
         case (hit(paddr))
            2'h1: aux_next = pwdata[7:0] & `EBSC_MASK_AUX;
            2'h2: clock_speed_control_next = pwdata[7:0] & `EBSC_MASK_CLOCK_SPEED_CONTROL;
            2'h3: p3_next = pwdata[7:0];
            default: pslverr_next = (paddr != `EBSC_ADDR_STATUS);
         endcase
      end
      else if (acc)
      begin
         case (hit(paddr))
            2'h1: prdata_next = {24'h0, aux_reg};
            2'h2: prdata_next = {24'h0, clock_speed_control_reg};
            2'h3: prdata_next = {24'h0, p3_reg};
            default:
            begin
               prdata_next  = (paddr == `EBSC_ADDR_STATUS) ?
                              {26'h0, x2_active, ea_latch_reg, fext_reg, st_reg[2], dev_rst_reg, program_pulse_in_reg} : 32'h0;
               pslverr_next = (paddr != `EBSC_ADDR_STATUS);
            end
         endcase
      end
   end

   // ----------------------------------------
   // Reset pin qualifier and code select latch
   // ----------------------------------------
   always_comb
   begin
      // count two machine cycles of periods
      rst_need      = {1'b0, (x2_active ? `EBSC_X2_PERIODS : `EBSC_STD_PERIODS)} << 1;
      rst_cnt_next  = rst_level ? ((rst_cnt_reg < rst_need) ? rst_cnt_reg + 5'd1 : rst_cnt_reg) : 5'd0;
      dev_rst_next  = (rst_cnt_reg >= rst_need) || watchdog_reset;
      rpo_next      = watchdog_reset;
      // take code select at first cycle end, once the synchroniser has settled
      ea_taken_next = dev_rst_reg ? 1'b0 : (ea_taken_reg || cycle_end);
      ea_latch_next = (!ea_taken_reg) ? ea_level : ea_latch_reg;
      program_pulse_in_next     = flash_programming ? program_pulse_in_level : 1'b0;
   end
   assign ext_code = security_level1 ? !ea_latch_reg : !ea_level;
   // ----------------------------------------
   // Bus sequencer and strobes
   // ----------------------------------------
   always_comb
   begin
      logic [3:0] half;
      logic       first_half;
      half         = x2_active ? 4'h3 : 4'h6;
      first_half   = phase < half;
      st_next      = st_reg;
      hi_next      = hi_reg;
      lo_next      = lo_reg;
      wr_n_next    = 1'b1;
      rd_n_next    = 1'b1;
      fext_next    = ext_code && fetch_req;
      if (cycle_end)
         st_next = data_req ? EBSC_DATA : (fetch_req ? (ext_code ? EBSC_FETCH : EBSC_HOLD) : EBSC_IDLE);
      case (st_reg)
         EBSC_FETCH:
         begin
            // latch pulse at start of each half
            ale_next    = (phase == 4'h0) || (phase == half);
            code_read_strobe_n_next = !((phase == 4'h2) || (phase == half + 4'h2));
            hi_next     = bus_addr[15:8];
            lo_next     = bus_addr[7:0];
         end
         EBSC_DATA:
         begin
            // one latch pulse only, second skipped
            ale_next    = (phase == 4'h0) && !flash_programming;
            code_read_strobe_n_next = 1'b1;
            hi_next     = data_wide ? bus_addr[15:8] : p3_reg;
            lo_next     = bus_addr[7:0];
            wr_n_next   = !(data_write && !first_half);
            rd_n_next   = !(!data_write && !first_half);
         end
         EBSC_HOLD, EBSC_IDLE:
         begin
            // internal fetch or idle: no code strobe, latch only if enabled
            ale_next    = !aux_reg[`EBSC_BIT_STROBE_OFF] && ((phase == 4'h0) || (phase == half));
            code_read_strobe_n_next = 1'b1;
         end
         default:
         begin
            ale_next    = 1'b0;
            code_read_strobe_n_next = 1'b1;
         end
      endcase
      if (flash_programming)
         ale_next = 1'b0;
   end
   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_reg      <= `EBSC_RST_AUX_CONTROL;
         clock_speed_control_reg    <= `EBSC_RST_CLOCK_SPEED;
         p3_reg       <= `EBSC_RST_PORT3_LATCH;
         pready_reg   <= 1'b0;
         prdata_reg   <= 32'h0;
         pslverr_reg  <= 1'b0;
         rst_cnt_reg  <= 5'd0;
         dev_rst_reg  <= 1'b1;
         ea_latch_reg <= 1'b1;
         ea_taken_reg <= 1'b0;
         rpo_reg      <= 1'b0;
         rpo_oe_n_reg <= 1'b1;
         program_pulse_in_reg     <= 1'b0;
         lat_oe_n_reg <= 1'b0;
         fext_reg     <= 1'b0;
         st_reg       <= EBSC_IDLE;
         ale_reg      <= 1'b0;
         code_read_strobe_n_reg   <= 1'b1;
         p3o_reg      <= `EBSC_RST_PORT3_LATCH;
         hi_reg       <= 8'hFF;
         lo_reg       <= 8'hFF;
      end
      else
      begin
         aux_reg      <= aux_next;
         clock_speed_control_reg    <= clock_speed_control_next;
         p3_reg       <= p3_next;
         pready_reg   <= pready_next;
         prdata_reg   <= prdata_next;
         pslverr_reg  <= pslverr_next;
         rst_cnt_reg  <= rst_cnt_next;
         dev_rst_reg  <= dev_rst_next;
         ea_latch_reg <= ea_latch_next;
         ea_taken_reg <= ea_taken_next;
         rpo_reg      <= rpo_next;
         rpo_oe_n_reg <= !rpo_next;
         program_pulse_in_reg     <= program_pulse_in_next;
         lat_oe_n_reg <= flash_programming;
         fext_reg     <= fext_next;
         // strobes held idle while device reset stands
         st_reg       <= dev_rst_reg ? EBSC_IDLE : st_next;
         ale_reg      <= dev_rst_reg ? 1'b0 : ale_next;
         code_read_strobe_n_reg   <= dev_rst_reg ? 1'b1 : code_read_strobe_n_next;
         p3o_reg      <= {(dev_rst_reg | rd_n_next) & p3_next[7], (dev_rst_reg | wr_n_next) & p3_next[6],
                          p3_next[5:0]};
         hi_reg       <= hi_next;
         lo_reg       <= lo_next;
      end
   end

   // ----------------------------------------
   // Outputs, all from flops
   // ----------------------------------------
   assign pready             = pready_reg;
   assign prdata             = prdata_reg;
   assign pslverr            = pslverr_reg;
   assign latch_strobe       = ale_reg;
   assign latch_oe_n         = lat_oe_n_reg; // Released for all of programming, so the pulse can come in.
   assign code_read_strobe_n = code_read_strobe_n_reg;
   assign high_addr_port     = hi_reg;
   assign low_addr_out       = lo_reg;
   assign port3_out          = p3o_reg;
   assign reset_pin_out      = rpo_reg;
   assign reset_pin_oe_n     = rpo_oe_n_reg;
   assign device_reset       = dev_rst_reg;
   assign program_pulse_in   = program_pulse_in_reg;
   assign fetch_external     = fext_reg;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_data_half;
      st_reg == EBSC_DATA && phase == (x2_active ? 4'h3 : 4'h6);
   endsequence
   AST_DATA_NO_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg == EBSC_DATA |=> code_read_strobe_n)
      else $error("code strobe during data access");
   AST_INTERNAL_NO_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg == EBSC_HOLD |=> code_read_strobe_n)
      else $error("code strobe on internal fetch");
   AST_RESET_STROBES: assert property (@(posedge pclk) disable iff (!presetn)
      dev_rst_reg |=> code_read_strobe_n && !latch_strobe && port3_out[7] == p3_reg[7])
      else $error("strobe active in reset");
   AST_WDOG_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      watchdog_reset |=> reset_pin_out && !reset_pin_oe_n)
      else $error("watchdog reset not driven");
   AST_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn)
      aux_reg[0] && st_reg == EBSC_HOLD && !dev_rst_reg |=> !latch_strobe)
      else $error("latch strobe not suppressed");
   AST_FETCH_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg == EBSC_FETCH && phase == 4'h2 && !dev_rst_reg |=> !code_read_strobe_n)
      else $error("missing code strobe");
   AST_DATA_ONE_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      s_data_half |=> !latch_strobe)
      else $error("second latch pulse in data cycle");
   AST_SPEED_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      clock_speed_control_reg[0] == 1'b0 |-> ##1 !x2_active || $past(x2_active) || $past(clock_speed_control_reg[0]))
      else $error("double speed without request");
endmodule // ebsc_bus_strobe

// ### ebsc_bus_strobe_bench.sv
// Self-checking bench for the external bus strobe controller.
// Assumes the package, the design and ebsc_ext_mem are compiled first.
`timescale 1ns/1ns
`include "ebsc_defs.svh"

module ebsc_bus_strobe_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        fetch_req, data_req, data_write, data_wide, watchdog_reset;
   logic        security_level1, ext_sel, flash_programming, rst_drive, program_pulse_in_drive;
   logic [15:0] bus_addr, fetch_addr, data_addr;
   logic        reset_pin_in, reset_pin_out, reset_pin_oe_n, latch_pin_in;
   logic        latch_strobe, latch_oe_n, code_read_strobe_n, device_reset;
   logic        program_pulse_in, fetch_external, err;
   logic [7:0]  high_addr_port, low_addr_out, port3_out;
   int          latch_cnt, code_cnt, rd_cnt, wr_cnt, n;
   int          fail_count = 0;
   int          num_checks = 0;
   logic [31:0] seed = 32'h0000EA88;
   logic [11:0] r_addr [3] = '{`EBSC_ADDR_AUX_CONTROL, `EBSC_ADDR_CLOCK_SPEED,
                               `EBSC_ADDR_PORT3_LATCH};
   logic [7:0]  r_mask [3] = '{`EBSC_MASK_AUX, `EBSC_MASK_CLOCK_SPEED_CONTROL, 8'hFF};
   logic [7:0]  r_rst  [3] = '{8'h08, 8'h00, 8'hFF};
   logic [7:0]  mdl    [3];

   // Two-way pins resolve to the design when its enable is low.
   assign reset_pin_in = !reset_pin_oe_n ? reset_pin_out : rst_drive;
   assign latch_pin_in = !latch_oe_n ? latch_strobe : program_pulse_in_drive;

   ebsc_bus_strobe u_ebsc_bus_strobe (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch_req(fetch_req),
      .data_req(data_req), .data_write(data_write), .data_wide(data_wide),
      .bus_addr(bus_addr), .watchdog_reset(watchdog_reset),
      .security_level1(security_level1), .reset_pin_in(reset_pin_in),
      .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
      .latch_pin_in(latch_pin_in), .latch_strobe(latch_strobe), .latch_oe_n(latch_oe_n),
      .code_read_strobe_n(code_read_strobe_n), .external_code_select(ext_sel),
      .flash_programming(flash_programming), .high_addr_port(high_addr_port),
      .low_addr_out(low_addr_out), .port3_out(port3_out), .device_reset(device_reset),
      .program_pulse_in(program_pulse_in), .fetch_external(fetch_external));

   ebsc_ext_mem u_ebsc_ext_mem (.pclk(pclk), .latch_strobe(latch_strobe),
      .code_read_strobe_n(code_read_strobe_n), .high_addr_port(high_addr_port),
      .low_addr_out(low_addr_out), .port3_out(port3_out), .latch_cnt(latch_cnt),
      .code_cnt(code_cnt), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt),
      .fetch_addr(fetch_addr), .data_addr(data_addr));

   // Free-running 10 MHz clock.
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_bit(input string nm, input logic e, input logic g);
      check_val(nm, {31'h0, e}, {31'h0, g});
   endtask

   // A wait that runs out ends the run as a mismatch.
   task automatic give_up(input int cnt);
      if (cnt >= 300)
      begin
         fail_count++;
         $display("ERROR wait expected done seen timeout");
         complete_run();
      end
   endtask

   // One APB transfer; request held until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 300);
      give_up(n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Ten machine cycles of traffic, with one data access when kind is 1 or 2.
   task automatic measure(input int mc, input int kind, input int bl, input int bc);
      int l0, c0, r0, w0, d;
      l0 = latch_cnt;
      c0 = code_cnt;
      r0 = rd_cnt;
      w0 = wr_cnt;
      d = (kind != 0);
      repeat (24) @(posedge pclk);
      data_req <= (kind != 0);
      data_write <= (kind == 2);
      repeat (mc) @(posedge pclk);
      data_req <= 1'b0;
      repeat (9 * mc - 24) @(posedge pclk);
      check_val("latch pulses", bl - d, latch_cnt - l0);
      check_val("code strobes", bc - 2 * d, code_cnt - c0);
      check_val("read strobes", kind == 1, rd_cnt - r0);
      check_val("write strobes", kind == 2, wr_cnt - w0);
      if (kind != 0)
         check_val("data address", bus_addr, data_addr);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // Main sequence.
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {fetch_req, data_req, data_write, data_wide, watchdog_reset} = '0;
      {security_level1, flash_programming, rst_drive, program_pulse_in_drive} = '0;
      ext_sel = 1'b1;
      bus_addr = 16'h0000;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      check_bit("code strobe in reset", 1'b1, code_read_strobe_n);
      check_val("port3 in reset", 8'hFF, port3_out);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, r_addr[i], 32'h0);
         check_val("reset value", {24'h0, r_rst[i]}, rd);
      end
      apb(1'b0, 12'h004, 32'h0);
      check_bit("unmapped error", 1'b1, err);
      check_val("unmapped data", 32'h0, rd);
      for (int i = 0; i < 9; i++)
      begin
         mdl[i % 3] = next_rand();
         apb(1'b1, r_addr[i % 3], {24'h0, mdl[i % 3]});
         apb(1'b0, r_addr[i % 3], 32'h0);
         check_val("register", {24'h0, mdl[i % 3] & r_mask[i % 3]}, rd);
      end
      apb(1'b1, `EBSC_ADDR_AUX_CONTROL, 32'h08);
      apb(1'b1, `EBSC_ADDR_PORT3_LATCH, 32'hFF);
      // external code at one random address, both speeds.
      ext_sel <= 1'b0;
      fetch_req <= 1'b1;
      data_wide <= 1'b1;
      bus_addr <= next_rand();
      for (int x = 0; x < 2; x++)
      begin
         apb(1'b1, `EBSC_ADDR_CLOCK_SPEED, x);
         repeat (36) @(posedge pclk);
         for (int k = 0; k < 3; k++)
            measure(x ? 6 : 12, k, 20, 20);
      end
      check_val("fetch address", bus_addr, fetch_addr);
      apb(1'b1, `EBSC_ADDR_CLOCK_SPEED, 32'h0);
      ext_sel <= 1'b1;
      repeat (36) @(posedge pclk);
      measure(12, 0, 20, 0);
      apb(1'b1, `EBSC_ADDR_AUX_CONTROL, 32'h09);
      repeat (36) @(posedge pclk);
      measure(12, 0, 0, 0);
      watchdog_reset <= 1'b1;
      for (n = 0; reset_pin_oe_n !== 1'b0 && n < 300; n++)
         @(posedge pclk);
      give_up(n);
      @(posedge pclk);
      check_bit("reset pin driven", 1'b1, reset_pin_out);
      watchdog_reset <= 1'b0;
      repeat (60) @(posedge pclk);
      // short pulse ignored, long pulse resets.
      rst_drive <= 1'b1;
      repeat (16) @(posedge pclk);
      check_bit("short reset pulse", 1'b0, device_reset);
      repeat (24) @(posedge pclk);
      check_bit("long reset pulse", 1'b1, device_reset);
      check_bit("code strobe held", 1'b1, code_read_strobe_n);
      rst_drive <= 1'b0;
      for (n = 0; device_reset !== 1'b0 && n < 300; n++)
         @(posedge pclk);
      give_up(n);
      flash_programming <= 1'b1;
      repeat (4) @(posedge pclk);
      check_bit("latch pin released", 1'b1, latch_oe_n);
      for (int p = 1; p >= 0; p--)
      begin
         program_pulse_in_drive <= p;
         repeat (8) @(posedge pclk);
         check_bit("program pulse", p, program_pulse_in);
      end
      flash_programming <= 1'b0;
      security_level1 <= 1'b1;
      ext_sel <= 1'b0;
      do_reset();
      repeat (30) @(posedge pclk);
      ext_sel <= 1'b1;
      repeat (8) @(posedge pclk);
      check_bit("latched code select", 1'b1, fetch_external);
      security_level1 <= 1'b0;
      repeat (8) @(posedge pclk);
      check_bit("code select follows", 1'b0, fetch_external);
      security_level1 <= 1'b1;
      do_reset();
      repeat (30) @(posedge pclk);
      ext_sel <= 1'b0;
      repeat (8) @(posedge pclk);
      check_bit("latched internal select", 1'b0, fetch_external);
      complete_run();
   end
endmodule // ebsc_bus_strobe_bench

// ### ebsc_defs.svh
// Constants for the external bus strobe controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and design modules.
`ifndef EBSC_DEFS_SVH
`define EBSC_DEFS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define EBSC_IDX_AUX_CONTROL   8'h8E
`define EBSC_IDX_CLOCK_SPEED   8'h8F
`define EBSC_IDX_PORT3_LATCH   8'hB0
`define EBSC_IDX_BUS_CMD       8'hC0
`define EBSC_IDX_STATUS        8'hC1
`define EBSC_ADDR_AUX_CONTROL  12'h238
`define EBSC_ADDR_CLOCK_SPEED  12'h23C
`define EBSC_ADDR_PORT3_LATCH  12'h2C0
`define EBSC_ADDR_BUS_CMD      12'h300
`define EBSC_ADDR_STATUS       12'h304

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define EBSC_RST_AUX_CONTROL   8'h08
`define EBSC_RST_CLOCK_SPEED   8'h00
`define EBSC_RST_PORT3_LATCH   8'hFF
`define EBSC_BIT_STROBE_OFF    0
`define EBSC_BIT_DOUBLE_SPEED  0
`define EBSC_BIT_WRITE_PIN     6
`define EBSC_BIT_READ_PIN      7
`define EBSC_MASK_AUX          8'h29
`define EBSC_MASK_CLOCK_SPEED_CONTROL        8'h7F

// ----------------------------------------
// Timing
// ----------------------------------------
`define EBSC_STD_PERIODS       4'hC
`define EBSC_X2_PERIODS        4'h6
`define EBSC_RESET_MCYCLES     2
`define EBSC_SYNC_STAGES       3

`endif

// ### ebsc_ext_mem.sv
// Model of the external program memory, data memory and address latch.
// Assumes the design drives its bus pins from registers on pclk.
`timescale 1ns/1ns

module ebsc_ext_mem
(
   // Clock
   input  wire logic        pclk,
   // Bus pins
   input  wire logic        latch_strobe,
   input  wire logic        code_read_strobe_n,
   input  wire logic [7:0]  high_addr_port,
   input  wire logic [7:0]  low_addr_out,
   input  wire logic [7:0]  port3_out,
   // Activity seen by the memories
   output int               latch_cnt,
   output int               code_cnt,
   output int               rd_cnt,
   output int               wr_cnt,
   output logic [15:0]      fetch_addr,
   output logic [15:0]      data_addr
);
   logic [7:0] low_reg;
   logic [3:0] prev;

   // Counts start empty; pins idle as during reset.
   initial
   begin
      {latch_cnt, code_cnt, rd_cnt, wr_cnt} = '0;
      prev = 4'h7;
   end

   // Edges are counted, so a long strobe is one access.
   always @(posedge pclk)
   begin
      prev <= {latch_strobe, code_read_strobe_n, port3_out[7:6]};
      if (latch_strobe)
         low_reg <= low_addr_out;
      if (latch_strobe && !prev[3])
         latch_cnt <= latch_cnt + 1;
      // code read with high byte on port.
      if (!code_read_strobe_n && prev[2])
      begin
         code_cnt <= code_cnt + 1;
         fetch_addr <= {high_addr_port, low_reg};
      end
      // data strobes on port 3 pins.
      if (!port3_out[7] && prev[1])
         rd_cnt <= rd_cnt + 1;
      if (!port3_out[6] && prev[0])
         wr_cnt <= wr_cnt + 1;
      if ((!port3_out[7] && prev[1]) || (!port3_out[6] && prev[0]))
         data_addr <= {high_addr_port, low_reg};
   end
endmodule // ebsc_ext_mem

// ### ebsc_phase_gen.sv
// Machine-cycle phase generator: oscillator-period enable counter.
// Assumes one pclk per oscillator period; x2 retimed at cycle boundary.
`timescale 1ns/1ns

module ebsc_phase_gen
   import ebsc_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Mode request and phase outputs
   input  wire logic       x2_req,
   output logic [3:0]      phase,
   output logic            x2_active,
   output logic            cycle_end
);

   logic [3:0] phase_reg;
   logic [3:0] phase_next;
   logic       x2_reg;
   logic       x2_next;
   logic [3:0] last;

   // Mode only changes at a cycle boundary, so no short cycle appears.
   always_comb
   begin
      last       = x2_reg ? (`EBSC_X2_PERIODS - 4'h1) : (`EBSC_STD_PERIODS - 4'h1);
      phase_next = (phase_reg == last) ? 4'h0 : phase_reg + 4'h1;
      x2_next    = (phase_reg == last) ? x2_req : x2_reg;
   end

   // Registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_reg <= 4'h0;
         x2_reg    <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         x2_reg    <= x2_next;
      end
   end

   assign phase     = phase_reg;
   assign x2_active = x2_reg;
   assign cycle_end = (phase_reg == last);

endmodule // ebsc_phase_gen

// ### ebsc_pin_sync.sv
// Three-flop pin synchroniser with agreement filter.
// Assumes an asynchronous, clock-free input pin.
`timescale 1ns/1ns

module ebsc_pin_sync
   import ebsc_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
)
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);

   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       level_reg;
   logic       level_next;

   // The first stage feeds only the second; the filter reads stages two and three.
   always_comb
   begin
      stage_next = {stage_reg[1:0], pin_in};
      level_next = ebsc_agree(stage_reg, level_reg);
   end

   // Registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage_reg <= {3{RESET_VAL}};
         level_reg <= RESET_VAL;
      end
      else
      begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;

endmodule // ebsc_pin_sync

// ### ebsc_pkg.sv
// Types for the external bus strobe controller.
// Assumes ebsc_defs.svh is on the include path.
`include "ebsc_defs.svh"

package ebsc_pkg;

   // Bus sequencer state, the kind of access chosen once per machine cycle.
   typedef enum logic [3:0] {
      EBSC_IDLE  = 4'b0001,
      EBSC_FETCH = 4'b0010,
      EBSC_DATA  = 4'b0100,
      EBSC_HOLD  = 4'b1000
   } ebsc_state_type;

   // Pin synchroniser: three flops, change taken once last two agree.
   function automatic logic ebsc_agree(input logic [2:0] s, input logic prev);
      ebsc_agree = (s[2] == s[1]) ? s[1] : prev;
   endfunction

endpackage
